// >>> hdl/tick_prescaler.v
// tick_prescaler.v - divides the core clock into a one-cycle count tick
// assumes: clk_sel is steady while enabled; all inputs are on core_clk
`timescale 1ns/100ps
`include "timer_consts.vh"

module tick_prescaler (
	input  wire       core_clk,
	input  wire       rstn,
	input  wire       run,
	input  wire [2:0] clk_sel,
	output reg        tick_ff
);

	reg  [9:0] div_ff;
	reg  [9:0] nxt_div;
	reg  [9:0] last;

	// ratios 1,2,4,8,16,64,256,1024
	always @* begin
		case (clk_sel)
			3'h0: last = `PRESC_LAST_DIV1;
			3'h1: last = `PRESC_LAST_DIV2;
			3'h2: last = `PRESC_LAST_DIV4;
			3'h3: last = `PRESC_LAST_DIV8;
			3'h4: last = `PRESC_LAST_DIV16;
			3'h5: last = `PRESC_LAST_DIV64;
			3'h6: last = `PRESC_LAST_DIV256;
			default: last = `PRESC_LAST_DIV1024;
		endcase
		nxt_div = (div_ff >= last) ? 10'h000 : div_ff + 10'h001;
	end

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			div_ff  <= 10'h000;
			tick_ff <= 1'b0;
		end else if (!run) begin
			div_ff  <= 10'h000; // [R24]
			tick_ff <= 1'b0;
		end else begin
			div_ff  <= nxt_div;
			tick_ff <= (div_ff >= last); // [R24]
		end
	end

endmodule // tick_prescaler

// >>> hdl/timer_consts.vh
// timer_consts.vh - register offsets, field positions and reset values of the timer core
// assumes: included by bare name into the timer design files
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// *****************************************
// register offsets (16-bit word address on the plain port)
// *****************************************
`define OFS_CTRL_ONE     5'h00
`define OFS_CTRL_TWO     5'h01
`define OFS_CTRL_FIVE    5'h02
`define OFS_CTRL_SIX     5'h03
`define OFS_EVENT_CTRL   5'h04
`define OFS_FLAGS        5'h05
`define OFS_COUNT        5'h06
`define OFS_PERIOD       5'h07
`define OFS_PERIOD_BUF   5'h08
`define OFS_CMP0         5'h09
`define OFS_CMP1         5'h0a
`define OFS_CMP2         5'h0b
`define OFS_CMP_BUF0     5'h0c
`define OFS_CMP_BUF1     5'h0d
`define OFS_CMP_BUF2     5'h0e

// *****************************************
// field positions
// *****************************************
`define ENABLE_BIT       0
`define CLOCK_SELECT_LSB       1
`define CLOCK_SELECT_MSB       3
`define WAVEFORM_MODE_LSB       0
`define WAVEFORM_MODE_MSB       2
`define CMPEN_LSB        4
`define DIR_BIT          0
`define PERIOD_BUFFER_VALID_BIT        0
`define CMPBV_LSB        1
`define EVENT_COUNT_ENABLE_BIT        0

// *****************************************
// waveform modes
// *****************************************
`define WG_NORMAL        3'h0
`define WG_FRQ           3'h1
`define WG_SINGLESLOPE   3'h3

// *****************************************
// prescaler terminal counts (ratio minus one)
// *****************************************
`define PRESC_LAST_DIV1     10'h000
`define PRESC_LAST_DIV2     10'h001
`define PRESC_LAST_DIV4     10'h003
`define PRESC_LAST_DIV8     10'h007
`define PRESC_LAST_DIV16    10'h00f
`define PRESC_LAST_DIV64    10'h03f
`define PRESC_LAST_DIV256   10'h0ff
`define PRESC_LAST_DIV1024  10'h3ff

// *****************************************
// reset values
// *****************************************
`define PERIOD_RESET     16'hffff
`define CMP_RESET        16'h0000
`define COUNT_RESET      16'h0000

`endif

// >>> hdl/timer_core.v
// timer_core.v - 16-bit buffered timer/counter with three compare channels
// assumes: one core clock, registers on a plain strobe port, event input asynchronous
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/100ps
`include "timer_consts.vh"

// Summary of operation
// R1 - bottom zero, max all ones, top sequence end
// R2 - update at bottom or top per mode
// R3 - count prescaled ticks in chosen direction
// R4 - upward at top wraps to zero next
// R5 - downward at bottom reloads period value
// R6 - count register write wins, immediate
// R7 - direction may change while running
// R8 - enable starts; event enable counts events
// R9 - buffers with valid flags, copied on update
// R10 - active and buffer registers directly writable
// R11 - unbuffered period write compares at once
// R12 - lower new top: run to max, wrap
// R13 - buffered period moves only on update
// R14 - compare match sets flag next tick
// R15 - compare buffer copied only on update
// R16 - pin driven only in mode, clock, enabled
// R17 - frequency mode: compare sets period, toggles
// R18 - frequency output period 2N(compare+1)
// R19 - single slope: set at top, clear match
// R20 - software keeps pwm period 0x0003..max
// R21 - single slope period N(period+1) clocks
// R22 - counter, period, compares all 16 bits
// R23 - three compare channels, each complete
// R24 - prescaler ticks every N; held when off
// R25 - buffered value active before next compare
module timer_core (
	input  wire        core_clk,
	input  wire        rstn,
	input  wire [4:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire        event_in,
	output reg  [15:0] reg_rdata_ff,
	output reg  [2:0]  waveform_out_ff,
	output reg  [2:0]  waveform_oe_n_ff
);

	// *****************************************
	// registers
	// *****************************************
	reg         enable_ff;
	reg  [2:0]  clock_select_ff;
	reg  [2:0]  waveform_mode_ff;
	reg  [2:0]  compare_output_enable_ff;
	reg         dir_down_ff;
	reg         event_count_enable_ff;
	reg  [15:0] count_value_ff; // [R22]
	reg  [15:0] period_ff;
	reg  [15:0] period_buffer_ff;
	reg         period_buffer_valid_ff;
	reg  [15:0] compare_value_ff [0:2];
	reg  [15:0] compare_buffer_ff [0:2];
	reg  [2:0]  compare_buffer_valid_ff;
	reg  [2:0]  match_flag_ff;
	reg         ovf_flag_ff;
	reg  [2:0]  waveform_signal_ff;
	reg  [2:0]  match_pend_ff;
	reg         ev_sync1_ff;
	reg         ev_sync2_ff;
	reg         ev_prev_ff;

	wire        presc_tick;
	wire        ev_tick;
	wire        tick;
	wire [15:0] top_val;
	wire        at_top;
	wire        at_bottom;
	wire        update;
	wire        wr_count;
	wire        frq_mode;
	wire        ss_mode;
	wire        wg_active;
	wire        wr_flags;
	reg  [15:0] nxt_count;
	reg  [2:0]  cmp_match;
	reg  [15:0] rd_mux;
	integer     i_buf;
	integer     i_cmp;
	integer     i_flg;
	integer     i_wav;
	integer     i_out;

	function is_addr;
		input [4:0] a;
		input [4:0] ofs;
		begin
			is_addr = (a == ofs);
		end
	endfunction

	// offset of channel ch counted from the channel 0 register
	function [4:0] cmp_addr;
		input [4:0] base;
		input integer ch;
		begin
			cmp_addr = base + ch[4:0];
		end
	endfunction

	// *****************************************
	// clock sources
	// *****************************************
	tick_prescaler u_presc (
		.core_clk (core_clk),
		.rstn     (rstn),
		.run      (enable_ff),
		.clk_sel  (clock_select_ff),
		.tick_ff  (presc_tick)
	);

	// event pin is asynchronous; rising edges count only after two stages
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ev_sync1_ff <= 1'b0;
			ev_sync2_ff <= 1'b0;
			ev_prev_ff  <= 1'b0;
		end else begin
			ev_sync1_ff <= event_in;
			ev_sync2_ff <= ev_sync1_ff;
			ev_prev_ff  <= ev_sync2_ff;
		end
	end

	assign ev_tick  = ev_sync2_ff & ~ev_prev_ff;
	assign tick     = enable_ff & (event_count_enable_ff ? ev_tick : presc_tick); // [R8] [R3]
	assign frq_mode = (waveform_mode_ff == `WG_FRQ);
	assign ss_mode  = (waveform_mode_ff == `WG_SINGLESLOPE);
	// frequency mode takes its period from channel 0
	assign top_val   = frq_mode ? compare_value_ff[0] : period_ff; // [R17]
	assign at_top    = (count_value_ff == top_val); // [R1] [R11]
	assign at_bottom = (count_value_ff == 16'h0000); // [R1]
	// single slope and frequency update at top when counting up, else at bottom
	assign update    = tick & (dir_down_ff ? at_bottom : at_top); // [R2]
	assign wr_count  = reg_wr & is_addr(reg_addr, `OFS_COUNT);
	assign wr_flags  = reg_wr & is_addr(reg_addr, `OFS_FLAGS);
	assign wg_active = (waveform_mode_ff != `WG_NORMAL) & ~event_count_enable_ff; // [R16]

	// *****************************************
	// counter
	// *****************************************
	always @* begin
		nxt_count = count_value_ff;
		if (dir_down_ff) begin
			if (at_bottom)
				nxt_count = top_val; // [R5]
			else
				nxt_count = count_value_ff - 16'h0001; // [R3] [R7]
		end else begin
			// equality only: a top below the count runs on through max [R12]
			if (at_top)
				nxt_count = 16'h0000; // [R4]
			else
				nxt_count = count_value_ff + 16'h0001; // [R3]
		end
	end

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			count_value_ff <= `COUNT_RESET;
		end else if (wr_count) begin
			count_value_ff <= reg_wdata; // [R6]
		end else if (tick) begin
			count_value_ff <= nxt_count;
		end
	end

	// *****************************************
	// control and buffered registers
	// *****************************************
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			enable_ff                <= 1'b0;
			clock_select_ff          <= 3'h0;
			waveform_mode_ff         <= `WG_NORMAL;
			compare_output_enable_ff <= 3'h0;
			dir_down_ff              <= 1'b0;
			event_count_enable_ff    <= 1'b0;
			period_ff                <= `PERIOD_RESET;
			period_buffer_ff         <= `PERIOD_RESET;
			period_buffer_valid_ff   <= 1'b0;
		end else begin
			// copy on update first; a same-cycle buffer write then wins [R25]
			if (update && period_buffer_valid_ff) begin
				period_ff              <= period_buffer_ff; // [R13] [R9]
				period_buffer_valid_ff <= 1'b0;
			end
			if (reg_wr) begin
				case (reg_addr)
					`OFS_CTRL_ONE: begin
						enable_ff       <= reg_wdata[`ENABLE_BIT]; // [R8]
						clock_select_ff <= reg_wdata[`CLOCK_SELECT_MSB:`CLOCK_SELECT_LSB];
					end
					`OFS_CTRL_TWO: begin
						waveform_mode_ff         <= reg_wdata[`WAVEFORM_MODE_MSB:`WAVEFORM_MODE_LSB];
						compare_output_enable_ff <= reg_wdata[`CMPEN_LSB+2:`CMPEN_LSB];
					end
					`OFS_CTRL_FIVE: dir_down_ff <= reg_wdata[`DIR_BIT]; // [R7]
					`OFS_EVENT_CTRL: event_count_enable_ff <= reg_wdata[`EVENT_COUNT_ENABLE_BIT];
					`OFS_PERIOD: period_ff <= reg_wdata; // [R10] [R11]
					`OFS_PERIOD_BUF: begin
						period_buffer_ff       <= reg_wdata; // [R10]
						period_buffer_valid_ff <= 1'b1; // [R9]
					end
					// compare registers are decoded in their own block
					default: ;
				endcase
			end
		end
	end

	// *****************************************
	// compare registers and buffers
	// *****************************************
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			compare_buffer_valid_ff <= 3'h0;
			for (i_buf = 0; i_buf < 3; i_buf = i_buf + 1) begin
				compare_value_ff[i_buf]  <= `CMP_RESET;
				compare_buffer_ff[i_buf] <= `CMP_RESET;
			end
		end else begin
			for (i_buf = 0; i_buf < 3; i_buf = i_buf + 1) begin
				// copy on update first; a same-cycle buffer write then wins [R25]
				if (update && compare_buffer_valid_ff[i_buf]) begin
					compare_value_ff[i_buf]        <= compare_buffer_ff[i_buf]; // [R15] [R9]
					compare_buffer_valid_ff[i_buf] <= 1'b0;
				end
				if (reg_wr && is_addr(reg_addr, cmp_addr(`OFS_CMP0, i_buf)))
					compare_value_ff[i_buf] <= reg_wdata; // [R10]
				if (reg_wr && is_addr(reg_addr, cmp_addr(`OFS_CMP_BUF0, i_buf))) begin
					compare_buffer_ff[i_buf]       <= reg_wdata; // [R10]
					compare_buffer_valid_ff[i_buf] <= 1'b1; // [R9]
				end
			end
		end
	end

	// *****************************************
	// compare channels and waveforms
	// *****************************************
	always @* begin
		for (i_cmp = 0; i_cmp < 3; i_cmp = i_cmp + 1)
			cmp_match[i_cmp] = (count_value_ff == compare_value_ff[i_cmp]); // [R14] [R23]
	end

	// a match latched on a tick raises its flag on the following tick
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			match_pend_ff <= 3'h0;
			match_flag_ff <= 3'h0;
			ovf_flag_ff   <= 1'b0;
		end else begin
			// a match left over from before a stop must not raise a flag on restart
			if (!enable_ff)
				match_pend_ff <= 3'h0;
			else if (tick)
				match_pend_ff <= cmp_match;
			for (i_flg = 0; i_flg < 3; i_flg = i_flg + 1) begin
				if (tick && match_pend_ff[i_flg])
					match_flag_ff[i_flg] <= 1'b1; // [R14]
				else if (wr_flags && reg_wdata[i_flg+1])
					match_flag_ff[i_flg] <= 1'b0;
			end
			// set wins over a same-cycle clear
			if (tick && (dir_down_ff ? at_bottom : at_top))
				ovf_flag_ff <= 1'b1;
			else if (wr_flags && reg_wdata[0])
				ovf_flag_ff <= 1'b0;
		end
	end

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			waveform_signal_ff <= 3'h0;
		end else if (tick && wg_active) begin
			for (i_wav = 0; i_wav < 3; i_wav = i_wav + 1) begin
				if (frq_mode && cmp_match[0] && i_wav == 0)
					waveform_signal_ff[i_wav] <= ~waveform_signal_ff[i_wav]; // [R17] [R18]
				else if (ss_mode && at_top)
					waveform_signal_ff[i_wav] <= 1'b1; // [R19] [R21]
				else if (ss_mode && cmp_match[i_wav])
					waveform_signal_ff[i_wav] <= 1'b0; // [R19]
			end
		end
	end

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			waveform_out_ff  <= 3'h0;
			waveform_oe_n_ff <= 3'h7;
		end else begin
			for (i_out = 0; i_out < 3; i_out = i_out + 1) begin
				waveform_out_ff[i_out]  <= waveform_signal_ff[i_out];
				waveform_oe_n_ff[i_out] <= ~(wg_active & compare_output_enable_ff[i_out]); // [R16]
			end
		end
	end

	// *****************************************
	// read port
	// *****************************************
	always @* begin
		rd_mux = 16'h0000;
		case (reg_addr)
			`OFS_CTRL_ONE:   rd_mux = {12'h000, clock_select_ff, enable_ff};
			`OFS_CTRL_TWO:   rd_mux = {9'h000, compare_output_enable_ff, 1'b0, waveform_mode_ff};
			`OFS_CTRL_FIVE:  rd_mux = {15'h0000, dir_down_ff};
			`OFS_CTRL_SIX:   rd_mux = {12'h000, compare_buffer_valid_ff, period_buffer_valid_ff};
			`OFS_EVENT_CTRL: rd_mux = {15'h0000, event_count_enable_ff};
			`OFS_FLAGS:      rd_mux = {12'h000, match_flag_ff, ovf_flag_ff};
			`OFS_COUNT:      rd_mux = count_value_ff;
			`OFS_PERIOD:     rd_mux = period_ff;
			`OFS_PERIOD_BUF: rd_mux = period_buffer_ff;
			`OFS_CMP0:       rd_mux = compare_value_ff[0];
			`OFS_CMP1:       rd_mux = compare_value_ff[1];
			`OFS_CMP2:       rd_mux = compare_value_ff[2];
			`OFS_CMP_BUF0:   rd_mux = compare_buffer_ff[0];
			`OFS_CMP_BUF1:   rd_mux = compare_buffer_ff[1];
			`OFS_CMP_BUF2:   rd_mux = compare_buffer_ff[2];
			default:         rd_mux = 16'h0000;
		endcase
	end

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			reg_rdata_ff <= 16'h0000;
		else if (reg_rd)
			reg_rdata_ff <= rd_mux;
		else
			reg_rdata_ff <= 16'h0000;
	end

endmodule // timer_core

// >>> tb/buffered_timer_pwm_core_tb.sv
// buffered_timer_pwm_core_tb.sv - self-checking bench for the timer core
// assumes: timer_consts.vh on the include path; pins modelled by wave_pins
`timescale 1ns/100ps
`include "timer_consts.vh"
module buffered_timer_pwm_core_tb;
	logic        core_clk = 1'b0;
	logic        rstn = 1'b0;
	logic [4:0]  reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        event_in = 1'b0;
	wire  [15:0] reg_rdata_ff;
	wire  [2:0]  waveform_out_ff;
	wire  [2:0]  waveform_oe_n_ff;
	wire  [2:0]  pin;
	logic [15:0] q;
	integer      seed = 32'h2d5f8404;
	int          error_cnt = 0;
	int          checked = 0;
	int          cyc = 0;
	int          per, p, c, s, i;
	int          m_cnt, m_top, m_dn;
	int          ratio [5] = '{1, 2, 4, 8, 16};

	always #2.5 core_clk = ~core_clk;

	timer_core i_timer_core (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .event_in(event_in),
		.reg_rdata_ff(reg_rdata_ff), .waveform_out_ff(waveform_out_ff),
		.waveform_oe_n_ff(waveform_oe_n_ff));
	wave_pins i_wave_pins (.waveform_out_ff(waveform_out_ff),
		.waveform_oe_n_ff(waveform_oe_n_ff), .pin(pin));

	task give_verdict;
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task rchk(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata_ff & m, e);
	endtask
	// read follows the write in the very next cycle
	task wr_rd(input logic [4:0] a, input logic [15:0] d, input logic [4:0] ra);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_addr <= ra;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 q = reg_rdata_ff;
	endtask
	// cycles between two rising edges seen on a pin
	task meas(input int ch);
		int k;
		k = 0;
		per = 0;
		// pins are looked at mid-cycle, away from the edge that launches them
		while (pin[ch] !== 1'b0 && k < 5000) begin @(negedge core_clk); k++; end
		while (pin[ch] !== 1'b1 && k < 5000) begin @(negedge core_clk); k++; end
		while (pin[ch] !== 1'b0 && k < 5000) begin @(negedge core_clk); k++; per++; end
		while (pin[ch] !== 1'b1 && k < 5000) begin @(negedge core_clk); k++; per++; end
	endtask
	task setup(input int sel, input logic [15:0] wg, input logic [15:0] top,
		input logic [15:0] cmp);
		wr(`OFS_CTRL_ONE, 16'h0000);
		// stale flags from the last test would hide a missed match
		wr(`OFS_FLAGS, 16'h000f);
		wr(`OFS_COUNT, 16'h0000);
		wr(`OFS_PERIOD, top);
		wr(`OFS_CMP0, cmp);
		wr(`OFS_CTRL_TWO, wg);
		wr(`OFS_CTRL_ONE, 16'(sel * 2 + 1));
	endtask
	task done(input string name);
		$display("test %s finished, mismatches %0d", name, error_cnt);
	endtask
	// event pulses; the model steps once per rising edge
	task pulses(input int n);
		repeat (n) begin
			event_in <= 1'b1;
			repeat (4) @(posedge core_clk);
			event_in <= 1'b0;
			repeat (4) @(posedge core_clk);
			if (m_dn)
				m_cnt = (m_cnt == 0) ? m_top : m_cnt - 1;
			else
				m_cnt = (m_cnt == m_top) ? 0 : (m_cnt + 1) % 65536;
		end
	endtask

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			$display("ERROR %0t run took too long", $time);
			give_verdict;
		end
	end

	initial begin
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		rchk(`OFS_PERIOD, 16'hffff, 16'hffff);
		rchk(`OFS_PERIOD_BUF, 16'hffff, 16'hffff);
		rchk(`OFS_COUNT, 16'hffff, 16'h0000);
		rchk(`OFS_CTRL_SIX, 16'hffff, 16'h0000);
		rchk(5'h1f, 16'hffff, 16'h0000);
		done("reset");
		p = $random(seed);
		wr_rd(`OFS_COUNT, 16'(p), `OFS_COUNT);
		chk(q, 16'(p));
		repeat (10) @(posedge core_clk);
		rchk(`OFS_COUNT, 16'hffff, 16'(p));
		done("hold");
		for (i = 0; i < 3; i++) begin
			s = {$random(seed)} % 5;
			p = 3 + {$random(seed)} % 13;
			c = 1 + {$random(seed)} % (p - 1);
			setup(s, 16'h0073, 16'(p), 16'(c));
			meas(0);
			chk(16'(per), 16'(ratio[s] * (p + 1)));
			rchk(`OFS_FLAGS, 16'h0002, 16'h0002);
		end
		done("pwm");
		for (i = 0; i < 2; i++) begin
			setup(i, 16'h0011, 16'hffff, 16'(i * 3));
			meas(0);
			chk(16'(per), 16'(2 * ratio[i] * (i * 3 + 1)));
		end
		done("frequency");
		setup(0, 16'h0073, 16'h0007, 16'h0003);
		wr_rd(`OFS_PERIOD_BUF, 16'h0009, `OFS_CTRL_SIX);
		chk(q & 16'h0001, 16'h0001);
		wr(`OFS_CMP_BUF0, 16'h0002);
		repeat (30) @(posedge core_clk);
		rchk(`OFS_CTRL_SIX, 16'hffff, 16'h0000);
		rchk(`OFS_PERIOD, 16'hffff, 16'h0009);
		rchk(`OFS_CMP0, 16'hffff, 16'h0002);
		meas(0);
		chk(16'(per), 16'h000a);
		done("buffer");
		wr(`OFS_EVENT_CTRL, 16'h0001);
		setup(0, 16'h0073, 16'hffff, 16'h0003);
		m_cnt = 0;
		m_top = 65535;
		m_dn = 0;
		pulses(5);
		rchk(`OFS_COUNT, 16'hffff, 16'(m_cnt));
		chk({13'h0000, pin}, 16'h0007);
		wr(`OFS_PERIOD, 16'h0003);
		wr(`OFS_CTRL_FIVE, 16'h0001);
		m_top = 3;
		m_dn = 1;
		pulses(7);
		rchk(`OFS_COUNT, 16'hffff, 16'(m_cnt));
		wr(`OFS_CTRL_FIVE, 16'h0000);
		wr(`OFS_COUNT, 16'hfffe);
		m_cnt = 65534;
		m_dn = 0;
		pulses(2);
		rchk(`OFS_COUNT, 16'hffff, 16'(m_cnt));
		done("events");
		give_verdict;
	end
endmodule // buffered_timer_pwm_core_tb

// >>> tb/timer_core_monitor.sv
// timer_core_monitor.sv - port-level checks of the timer core
// assumes: bound to timer_core, one clock domain
`timescale 1ns/100ps
`include "timer_consts.vh"
module timer_core_monitor (
	input wire logic        core_clk,
	input wire logic        rstn,
	input wire logic [4:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic        event_in,
	input wire logic [15:0] reg_rdata_ff,
	input wire logic [2:0]  waveform_out_ff,
	input wire logic [2:0]  waveform_oe_n_ff
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	logic [6:0] mode_ff;
	logic       evt_ff;
	logic [2:0] exp_oe_n;
	// shadow of the mode bits; tracked from writes since the body is hidden
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mode_ff <= 7'h00;
			evt_ff  <= 1'b0;
		end else if (reg_wr && reg_addr == `OFS_CTRL_TWO) begin
			mode_ff <= reg_wdata[6:0];
		end else if (reg_wr && reg_addr == `OFS_EVENT_CTRL) begin
			evt_ff <= reg_wdata[0];
		end
	end
	assign exp_oe_n = (mode_ff[2:0] != 3'h0 && !evt_ff) ? ~mode_ff[6:4] : 3'b111;
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata_ff == 16'h0000)
		else $error("read data not zero outside a read");
	a_count_write_wins: assert property (reg_wr && reg_addr == `OFS_COUNT ##1
		reg_rd && reg_addr == `OFS_COUNT |=> reg_rdata_ff == $past(reg_wdata, 2))
		else $error("count write not immediate");
	a_period_buffer_direct: assert property (reg_wr && reg_addr == `OFS_PERIOD_BUF ##1
		reg_rd && reg_addr == `OFS_PERIOD_BUF |=> reg_rdata_ff == $past(reg_wdata, 2))
		else $error("period buffer readback wrong");
	a_period_buffer_valid_set: assert property (reg_wr && reg_addr == `OFS_PERIOD_BUF ##1
		reg_rd && reg_addr == `OFS_CTRL_SIX |=> reg_rdata_ff[0])
		else $error("period valid flag not set");
	a_oe_override: assert property (exp_oe_n == $past(exp_oe_n) &&
		exp_oe_n == $past(exp_oe_n, 2) && exp_oe_n == $past(exp_oe_n, 3)
		|-> waveform_oe_n_ff == exp_oe_n)
		else $error("pin override enable wrong");
	a_unmapped_zero: assert property (reg_rd && reg_addr > 5'h0e |=> !reg_rdata_ff)
		else $error("unmapped read not zero");
	a_dir_narrow: assert property (reg_rd && reg_addr == `OFS_CTRL_FIVE
		|=> reg_rdata_ff[15:1] == 15'h0000)
		else $error("direction register upper bits set");
	a_flags_narrow: assert property (reg_rd && reg_addr == `OFS_FLAGS
		|=> reg_rdata_ff[15:4] == 12'h000)
		else $error("flag register upper bits set");
	c_override: cover property (waveform_oe_n_ff == 3'b000);
	c_event_mode: cover property (evt_ff && event_in);
	c_count_write: cover property (reg_wr && reg_addr == `OFS_COUNT ##1 reg_rd);
endmodule // timer_core_monitor

bind timer_core timer_core_monitor i_timer_core_monitor (.*);

// >>> tb/wave_pins.sv
// wave_pins.sv - port pins that receive the timer waveform outputs
// assumes: each pin has a pull-up that holds it high when released
`timescale 1ns/100ps
module wave_pins (
	input  wire logic [2:0] waveform_out_ff,
	input  wire logic [2:0] waveform_oe_n_ff,
	output wire logic [2:0] pin
);
	// a released pin shows the pull-up, never the last driven value
	assign pin = (waveform_out_ff & ~waveform_oe_n_ff) | waveform_oe_n_ff;
endmodule // wave_pins
